// ===== verilog/hub_port_pkg.sv
// Constants and types shared by the hub downstream-port feature handler
package hub_port_pkg;

	// Feature selectors accepted for a port recipient
	localparam logic [7:0] SEL_PORT_RESET  = 8'h04;
	localparam logic [7:0] SEL_LINK_STATE  = 8'h05;
	localparam logic [7:0] SEL_PORT_POWER  = 8'h08;
	localparam logic [7:0] SEL_U1_TIMEOUT  = 8'h17;
	localparam logic [7:0] SEL_U2_TIMEOUT  = 8'h18;
	localparam logic [7:0] SEL_WAKE_MASK   = 8'h1b;
	localparam logic [7:0] SEL_BH_RESET    = 8'h1c;
	localparam logic [7:0] SEL_FORCE_LINKPM = 8'h1e;

	// Link-state request values carried in the upper wIndex byte
	localparam logic [7:0] LS_VALUE_MAX    = 8'h05;

	typedef enum logic [2:0] {
		LINK_U0         = 3'b000,
		LINK_U1         = 3'b001,
		LINK_U2         = 3'b010,
		LINK_U3         = 3'b011,
		LINK_SS_DISABLED = 3'b100,
		LINK_RX_DETECT  = 3'b101,
		LINK_SS_INACTIVE = 3'b110,
		LINK_OTHER      = 3'b111
	} link_e;

	typedef enum logic [2:0] {
		PORT_POWERED_OFF  = 3'b000,
		PORT_DISCONNECTED = 3'b001,
		PORT_DISABLED     = 3'b010,
		PORT_ENABLED      = 3'b011,
		PORT_RESETTING    = 3'b100,
		PORT_OTHER        = 3'b101
	} port_e;

	// Remote wake mask layout
	localparam int         MASK_W        = 3;
	localparam int         MASK_CONN_BIT = 0;
	localparam int         MASK_DISC_BIT = 1;
	localparam int         MASK_OC_BIT   = 2;
	localparam logic [2:0] MASK_RESET    = 3'h0;

	// Wait for U0 before a U3 entry
	localparam int CLK_PERIOD_NS  = 8;
	localparam int WAIT_U0_NS     = 1000;
	localparam int WAIT_U0_CYCLES = WAIT_U0_NS / CLK_PERIOD_NS;

endpackage

// ===== verilog/wake_mask_bank.sv
// Per-port remote wake masks, change flags and upstream wake request
`timescale 1ns/1ps
module wake_mask_bank #(
	parameter int NPORTS      = 4,
	parameter bit PER_PORT_OC = 1'b1,
	parameter int PW          = (NPORTS > 1) ? $clog2(NPORTS) : 1
) (
	input  wire logic                 clock_i,
	input  wire logic                 rst_n_i,
	input  wire logic                 mask_we_i,
	input  wire logic [PW-1:0]        mask_idx_i,
	input  wire logic [2:0]           mask_val_i,
	input  wire logic                 suspended_i,
	input  wire logic [NPORTS-1:0]    connect_evt_i,
	input  wire logic [NPORTS-1:0]    disconnect_evt_i,
	input  wire logic [NPORTS-1:0]    overcurrent_evt_i,
	input  wire logic [NPORTS-1:0]    resume_evt_i,
	input  wire logic [NPORTS-1:0]    conn_change_clr_i,
	input  wire logic [NPORTS-1:0]    oc_change_clr_i,
	output logic      [3*NPORTS-1:0]  mask_o,
	output logic      [NPORTS-1:0]    conn_change_o,
	output logic      [NPORTS-1:0]    oc_change_o,
	output logic                      wake_o
);
	logic [2:0]        mask_q [NPORTS];
	logic [NPORTS-1:0] conn_en;
	logic [NPORTS-1:0] disc_en;
	logic [NPORTS-1:0] oc_en;
	logic              oc_wake;
	logic              wake_d;

	always_ff @(posedge clock_i)
	begin
		for (int p = 0; p < NPORTS; p++)
		begin
			if (!rst_n_i)
				mask_q[p] <= hub_port_pkg::MASK_RESET;
			else if (mask_we_i && (mask_idx_i == PW'(p)))
				mask_q[p] <= mask_val_i;
		end
	end

	always_comb
	begin
		for (int p = 0; p < NPORTS; p++)
		begin
			mask_o[3*p +: 3] = mask_q[p];
			conn_en[p]       = mask_q[p][hub_port_pkg::MASK_CONN_BIT];
			disc_en[p]       = mask_q[p][hub_port_pkg::MASK_DISC_BIT];
			oc_en[p]         = mask_q[p][hub_port_pkg::MASK_OC_BIT];
		end
	end

	// Shared sensing cannot tell which port tripped, so any enabled port counts
	always_comb
	begin
		if (PER_PORT_OC)
			oc_wake = |(overcurrent_evt_i & oc_en);
		else
			oc_wake = (|overcurrent_evt_i) && (|oc_en);
	end

	assign wake_d = suspended_i && ((|(connect_evt_i & conn_en))
		|| (|(disconnect_evt_i & disc_en))
		|| oc_wake || (|resume_evt_i));

	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
			wake_o <= 1'b0;
		else
			wake_o <= wake_d;
	end

	// Masked events still latch, so they are reported after resume; set wins
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			conn_change_o <= '0;
			oc_change_o   <= '0;
		end
		else
		begin
			conn_change_o <= (connect_evt_i | disconnect_evt_i)
				| (conn_change_o & ~conn_change_clr_i);
			oc_change_o   <= overcurrent_evt_i | (oc_change_o & ~oc_change_clr_i);
		end
	end

	a_mask_reset_zero: assert property (@(posedge clock_i)
		!rst_n_i |=> mask_o == '0) else $error("wake mask not cleared by reset");
	a_conn_masked: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(connect_evt_i[0] && !conn_en[0] && !(|disconnect_evt_i) && !(|overcurrent_evt_i)
		&& !(|resume_evt_i) && (connect_evt_i == {{(NPORTS-1){1'b0}}, 1'b1}))
		|=> !wake_o && conn_change_o[0]) else $error("masked connect woke or was lost");
	a_disc_wake: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(suspended_i && disconnect_evt_i[0] && disc_en[0]) |=> wake_o)
		else $error("enabled disconnect did not wake");
	c_wake_seen: cover property (@(posedge clock_i) disable iff (!rst_n_i) wake_o);

endmodule // wake_mask_bank

// ===== verilog/hub_port_feature_handler.sv
// Set Port Feature request handler for hub downstream ports
`timescale 1ns/1ps
module hub_port_feature_handler #(
	parameter int NPORTS      = 4,
	parameter bit PER_PORT_OC = 1'b1,
	parameter int PW          = (NPORTS > 1) ? $clog2(NPORTS) : 1
) (
	input  wire logic                clock_i,
	input  wire logic                rst_n_i,
	input  wire logic                req_valid_i,
	input  wire logic [7:0]          req_selector_i,
	input  wire logic [15:0]         req_windex_i,
	input  wire logic [15:0]         req_wlength_i,
	input  wire logic [2:0]          link_state_i [NPORTS],
	input  wire logic [2:0]          port_state_i [NPORTS],
	input  wire logic                suspended_i,
	input  wire logic [NPORTS-1:0]   connect_evt_i,
	input  wire logic [NPORTS-1:0]   disconnect_evt_i,
	input  wire logic [NPORTS-1:0]   overcurrent_evt_i,
	input  wire logic [NPORTS-1:0]   resume_evt_i,
	input  wire logic [NPORTS-1:0]   warm_done_i,
	input  wire logic [NPORTS-1:0]   warm_change_clr_i,
	input  wire logic [NPORTS-1:0]   conn_change_clr_i,
	input  wire logic [NPORTS-1:0]   oc_change_clr_i,
	output logic                     req_ready_o,
	output logic                     resp_valid_o,
	output logic                     resp_error_o,
	output logic [7:0]               cmd_port_o,
	output logic                     link_go_o,
	output logic [2:0]               link_go_state_o,
	output logic                     port_reset_o,
	output logic                     port_warm_reset_o,
	output logic                     port_power_on_o,
	output logic                     port_disable_o,
	output logic                     port_rx_detect_o,
	output logic                     force_accept_o,
	output logic [NPORTS-1:0]        fwd_allow_o,
	output logic [NPORTS-1:0]        warm_change_o,
	output logic [3*NPORTS-1:0]      wake_mask_o,
	output logic [NPORTS-1:0]        conn_change_o,
	output logic [NPORTS-1:0]        oc_change_o,
	output logic                     wake_o
);
	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_WAIT_U0 = 2'b01
	} state_e;

	localparam logic [9:0] WAIT_LAST = 10'(hub_port_pkg::WAIT_U0_CYCLES - 1);

	state_e          state_q, state_d;
	logic [PW-1:0]   held_idx_q;
	logic [9:0]      wait_cnt_q;
	logic [7:0]      port_num;
	logic [7:0]      hi_byte;
	logic            port_ok;
	logic            dec_err;
	logic            req_take;
	logic [PW-1:0]   cur_idx;
	logic [2:0]      cur_link;
	logic [2:0]      cur_port;
	logic            link_active;
	logic            resp_d, err_d, go_d, rst_d, warm_d, pwr_d, dis_d, rxd_d, frc_d;
	logic [2:0]      go_state_d;
	logic            mask_we;

	function automatic logic sel_known(input logic [7:0] sel);
		sel_known = (sel == hub_port_pkg::SEL_PORT_RESET) || (sel == hub_port_pkg::SEL_LINK_STATE)
			|| (sel == hub_port_pkg::SEL_PORT_POWER) || (sel == hub_port_pkg::SEL_U1_TIMEOUT)
			|| (sel == hub_port_pkg::SEL_U2_TIMEOUT) || (sel == hub_port_pkg::SEL_WAKE_MASK)
			|| (sel == hub_port_pkg::SEL_BH_RESET) || (sel == hub_port_pkg::SEL_FORCE_LINKPM);
	endfunction

	function automatic logic low_power(input logic [2:0] ls);
		low_power = (ls == hub_port_pkg::LINK_U1) || (ls == hub_port_pkg::LINK_U2)
			|| (ls == hub_port_pkg::LINK_U3);
	endfunction

	assign port_num = req_windex_i[7:0];
	assign hi_byte  = req_windex_i[15:8];
	assign port_ok  = (port_num != 8'h00) && (port_num <= 8'(NPORTS));
	assign req_take = req_valid_i && req_ready_o;
	assign dec_err  = !sel_known(req_selector_i) || !port_ok || (req_wlength_i != 16'h0000)
		|| ((req_selector_i == hub_port_pkg::SEL_LINK_STATE)
		&& (hi_byte > hub_port_pkg::LS_VALUE_MAX));
	assign cur_idx  = (state_q == ST_WAIT_U0) ? held_idx_q
		: (port_ok ? PW'(port_num - 8'h01) : '0);
	assign cur_link = link_state_i[cur_idx];
	assign cur_port = port_state_i[cur_idx];
	// Values 0 to 3 only act on an enabled port with a live link
	assign link_active = (cur_port == hub_port_pkg::PORT_ENABLED)
		&& (cur_link != hub_port_pkg::LINK_SS_DISABLED)
		&& (cur_link != hub_port_pkg::LINK_RX_DETECT)
		&& (cur_link != hub_port_pkg::LINK_SS_INACTIVE);

	always_comb
	begin
		state_d    = state_q;
		resp_d     = 1'b0;
		err_d      = 1'b0;
		go_d       = 1'b0;
		go_state_d = hub_port_pkg::LINK_U0;
		rst_d      = 1'b0;
		warm_d     = 1'b0;
		pwr_d      = 1'b0;
		dis_d      = 1'b0;
		rxd_d      = 1'b0;
		frc_d      = 1'b0;
		mask_we    = 1'b0;
		case (state_q)
			ST_IDLE:
			begin
				if (req_take)
				begin
					resp_d = 1'b1;
					if (dec_err)
						err_d = 1'b1;
					else
					begin
						case (req_selector_i)
							hub_port_pkg::SEL_PORT_RESET:
								rst_d = (cur_port != hub_port_pkg::PORT_POWERED_OFF);
							hub_port_pkg::SEL_BH_RESET:
								warm_d = (cur_port != hub_port_pkg::PORT_POWERED_OFF);
							hub_port_pkg::SEL_PORT_POWER:
								pwr_d = (cur_port == hub_port_pkg::PORT_POWERED_OFF);
							hub_port_pkg::SEL_FORCE_LINKPM:
								frc_d = (cur_port == hub_port_pkg::PORT_ENABLED);
							hub_port_pkg::SEL_WAKE_MASK:
								mask_we = 1'b1;
							hub_port_pkg::SEL_LINK_STATE:
							begin
								case (hi_byte[2:0])
									3'h0:
										go_d = link_active && low_power(cur_link);
									3'h1, 3'h2:
									begin
										// Outside U0 the link is left alone
										go_d       = link_active && (cur_link == hub_port_pkg::LINK_U0);
										go_state_d = hi_byte[2:0];
									end
									3'h3:
									begin
										if (link_active && (cur_link == hub_port_pkg::LINK_U0))
										begin
											go_d       = 1'b1;
											go_state_d = hub_port_pkg::LINK_U3;
										end
										else if (link_active && low_power(cur_link)
											&& (cur_link != hub_port_pkg::LINK_U3))
										begin
											go_d    = 1'b1;
											resp_d  = 1'b0;
											state_d = ST_WAIT_U0;
										end
									end
									3'h4:
									begin
										go_d       = 1'b1;
										go_state_d = hub_port_pkg::LINK_SS_DISABLED;
										dis_d      = 1'b1;
									end
									3'h5:
									begin
										go_d       = (cur_port == hub_port_pkg::PORT_DISABLED);
										go_state_d = hub_port_pkg::LINK_RX_DETECT;
										rxd_d      = go_d;
									end
									default:
										go_d = 1'b0;
								endcase
							end
							default:
								go_d = 1'b0;
						endcase
					end
				end
			end
			ST_WAIT_U0:
			begin
				// A link that never reaches U0 is given up on without error
				if (cur_link == hub_port_pkg::LINK_U0)
				begin
					go_d       = 1'b1;
					go_state_d = hub_port_pkg::LINK_U3;
					resp_d     = 1'b1;
					state_d    = ST_IDLE;
				end
				else if (wait_cnt_q == WAIT_LAST)
				begin
					resp_d  = 1'b1;
					state_d = ST_IDLE;
				end
			end
			default:
				state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			state_q     <= ST_IDLE;
			req_ready_o <= 1'b1;
			held_idx_q  <= '0;
			wait_cnt_q  <= 10'h000;
		end
		else
		begin
			state_q     <= state_d;
			req_ready_o <= (state_d == ST_IDLE);
			if (state_q == ST_IDLE)
			begin
				held_idx_q <= cur_idx;
				wait_cnt_q <= 10'h000;
			end
			else
				wait_cnt_q <= wait_cnt_q + 10'h001;
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			resp_valid_o      <= 1'b0;
			resp_error_o      <= 1'b0;
			cmd_port_o        <= 8'h00;
			link_go_o         <= 1'b0;
			link_go_state_o   <= 3'h0;
			port_reset_o      <= 1'b0;
			port_warm_reset_o <= 1'b0;
			port_power_on_o   <= 1'b0;
			port_disable_o    <= 1'b0;
			port_rx_detect_o  <= 1'b0;
			force_accept_o    <= 1'b0;
		end
		else
		begin
			resp_valid_o      <= resp_d;
			resp_error_o      <= err_d;
			link_go_o         <= go_d;
			link_go_state_o   <= go_state_d;
			port_reset_o      <= rst_d;
			port_warm_reset_o <= warm_d;
			port_power_on_o   <= pwr_d;
			port_disable_o    <= dis_d;
			port_rx_detect_o  <= rxd_d;
			force_accept_o    <= frc_d;
			if (go_d || rst_d || warm_d || pwr_d || frc_d)
				cmd_port_o <= 8'(cur_idx) + 8'h01;
		end
	end

	// Warm change flag: completion wins over a clear in the same cycle
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
			warm_change_o <= '0;
		else
			warm_change_o <= warm_done_i | (warm_change_o & ~warm_change_clr_i);
	end

	always_ff @(posedge clock_i)
	begin
		for (int p = 0; p < NPORTS; p++)
		begin
			if (!rst_n_i)
				fwd_allow_o[p] <= 1'b1;
			else
				fwd_allow_o[p] <= (link_state_i[p] != hub_port_pkg::LINK_U3);
		end
	end

	wake_mask_bank #(
		.NPORTS      (NPORTS),
		.PER_PORT_OC (PER_PORT_OC),
		.PW          (PW)
	) u_wake (
		.clock_i           (clock_i),
		.rst_n_i           (rst_n_i),
		.mask_we_i         (mask_we),
		.mask_idx_i        (cur_idx),
		.mask_val_i        (hi_byte[2:0]),
		.suspended_i       (suspended_i),
		.connect_evt_i     (connect_evt_i),
		.disconnect_evt_i  (disconnect_evt_i),
		.overcurrent_evt_i (overcurrent_evt_i),
		.resume_evt_i      (resume_evt_i),
		.conn_change_clr_i (conn_change_clr_i),
		.oc_change_clr_i   (oc_change_clr_i),
		.mask_o            (wake_mask_o),
		.conn_change_o     (conn_change_o),
		.oc_change_o       (oc_change_o),
		.wake_o            (wake_o)
	);

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	a_port_zero_err: assert property (req_take && (port_num == 8'h00)
		|=> resp_valid_o && resp_error_o) else $error("port zero accepted");
	a_wlength_err: assert property (req_take && (req_wlength_i != 16'h0000)
		|=> resp_valid_o && resp_error_o && !link_go_o) else $error("wLength not refused");
	a_ls_range_err: assert property (req_take && port_ok && (req_wlength_i == 16'h0000)
		&& (req_selector_i == hub_port_pkg::SEL_LINK_STATE) && (hi_byte > 8'h05)
		|=> resp_error_o) else $error("link value above 5 accepted");
	a_disable_any: assert property (req_take && !dec_err
		&& (req_selector_i == hub_port_pkg::SEL_LINK_STATE) && (hi_byte == 8'h04)
		|=> link_go_o && (link_go_state_o == 3'h4) && port_disable_o && !resp_error_o)
		else $error("SS.Disabled request not carried out");
	a_reset_off_noop: assert property (req_take && !dec_err
		&& (req_selector_i == hub_port_pkg::SEL_PORT_RESET)
		&& (cur_port == hub_port_pkg::PORT_POWERED_OFF)
		|=> !port_reset_o && resp_valid_o && !resp_error_o) else $error("reset of off port");
	a_power_noop: assert property (req_take && !dec_err
		&& (req_selector_i == hub_port_pkg::SEL_PORT_POWER)
		|=> port_power_on_o == ($past(cur_port) == hub_port_pkg::PORT_POWERED_OFF))
		else $error("power request gating wrong");
	a_u3_not_enabled: assert property (req_take && !dec_err
		&& (req_selector_i == hub_port_pkg::SEL_LINK_STATE) && (hi_byte == 8'h03)
		&& (cur_port != hub_port_pkg::PORT_ENABLED)
		|=> !link_go_o && resp_valid_o) else $error("U3 on non-enabled port");
	a_u3_via_u0: assert property (req_take && !dec_err && link_active
		&& (req_selector_i == hub_port_pkg::SEL_LINK_STATE) && (hi_byte == 8'h03)
		&& (cur_link == hub_port_pkg::LINK_U1)
		|=> link_go_o && (link_go_state_o == 3'h0) && !resp_valid_o && !req_ready_o)
		else $error("U3 from U1 not routed through U0");
	a_u1_undefined: assert property (req_take && !dec_err
		&& (req_selector_i == hub_port_pkg::SEL_LINK_STATE) && (hi_byte == 8'h01)
		&& (cur_link != hub_port_pkg::LINK_U0)
		|=> !link_go_o && resp_valid_o && !resp_error_o) else $error("U1 outside U0 acted");
	a_warm_flag: assert property (warm_done_i[0] |=> warm_change_o[0] [*2] or
		(warm_change_o[0] ##1 $past(warm_change_clr_i[0])))
		else $error("warm change flag not set");
	a_fwd_block: assert property (link_state_i[0] == hub_port_pkg::LINK_U3
		|=> !fwd_allow_o[0]) else $error("traffic allowed to suspended port");

	c_u3_two_step: cover property (state_q == ST_WAIT_U0 ##1 link_go_o && resp_valid_o);
	c_warm_reset: cover property (port_warm_reset_o);
	c_error_resp: cover property (resp_valid_o && resp_error_o);

endmodule // hub_port_feature_handler

// ===== test/port_model.sv
// Behavioural downstream port and link obeying the handler's commands
`timescale 1ns/1ps
module port_model (
	input	wire logic		clock_i,
	input	wire logic		rst_n_i,
	input	wire logic [7:0]	delay_i,
	input	wire logic		set_i,
	input	wire logic		set_idx_i,
	input	wire logic [2:0]	set_link_i,
	input	wire logic [2:0]	set_port_i,
	input	wire logic [7:0]	cmd_port_i,
	input	wire logic		link_go_i,
	input	wire logic [2:0]	link_go_state_i,
	input	wire logic		port_disable_i,
	input	wire logic		port_rx_detect_i,
	input	wire logic		port_warm_reset_i,
	output	logic [2:0]		link_state_o [2],
	output	logic [2:0]		port_state_o [2],
	output	logic [1:0]		warm_done_o
);
	// Settle time from delay_i, so a scenario picks a prompt or slow link
	logic		idx;
	logic		tidx_q;
	logic		warm_q;
	logic [2:0]	tgt_q;
	logic [7:0]	cnt_q;

	assign idx = (cmd_port_i == 8'h02);

	always_ff @(posedge clock_i)
	begin
		warm_done_o <= 2'h0;
		if (!rst_n_i)
		begin
			cnt_q <= 8'h00;
			tgt_q <= 3'h0;
			tidx_q <= 1'b0;
			warm_q <= 1'b0;
			link_state_o <= '{3'h0, 3'h0};
			port_state_o <= '{3'h0, 3'h0};
		end
		else if (set_i)
		begin
			link_state_o[set_idx_i] <= set_link_i;
			port_state_o[set_idx_i] <= set_port_i;
		end
		else if (link_go_i || port_warm_reset_i)
		begin
			cnt_q <= delay_i;
			tgt_q <= link_go_i ? link_go_state_i : 3'h0;
			tidx_q <= idx;
			warm_q <= port_warm_reset_i;
			if (port_warm_reset_i)
				port_state_o[idx] <= 3'h4;
			if (port_disable_i)
				port_state_o[idx] <= 3'h2;
			if (port_rx_detect_i)
				port_state_o[idx] <= 3'h1;
		end
		else if (cnt_q == 8'h01)
		begin
			cnt_q <= 8'h00;
			link_state_o[tidx_q] <= tgt_q;
			if (warm_q)
				port_state_o[tidx_q] <= 3'h3;
			warm_done_o[tidx_q] <= warm_q;
		end
		else if (cnt_q != 8'h00)
			cnt_q <= cnt_q - 8'h01;
	end
endmodule // port_model

// ===== test/hub_port_feature_handler_tb.sv
// Self-checking bench for the hub port feature handler
`timescale 1ns/1ps
module hub_port_feature_handler_tb;
	localparam logic [7:0] LS = hub_port_pkg::SEL_LINK_STATE,
		RST = hub_port_pkg::SEL_PORT_RESET,
		PWR = hub_port_pkg::SEL_PORT_POWER,
		FRC = hub_port_pkg::SEL_FORCE_LINKPM,
		BH = hub_port_pkg::SEL_BH_RESET,
		MSK = hub_port_pkg::SEL_WAKE_MASK,
		U1T = hub_port_pkg::SEL_U1_TIMEOUT;
	logic		clock, rst_n, req_valid, susp, set, sidx, err, rdy_lo, w;
	logic		req_ready, resp_valid, resp_error, link_go, wake;
	logic [2:0]	slink, sport, go_state, go_st, go_first;
	logic [7:0]	sel, delay, cmd_port;
	logic [15:0]	widx, wlen;
	logic [2:0]	link_state [2];
	logic [2:0]	port_state [2];
	logic [3:0][1:0]	ev;
	logic [1:0]	conn_clr, warm_done, fwd_allow, warm_change, conn_change, oc_change;
	logic [5:0]	wake_mask, seen;
	wire [5:0]	pulse;
	int		go_n;
	int		fail_count = 0;
	int		total_checks = 0;

	hub_port_feature_handler #(.NPORTS(2)) hub_port_feature_handler_inst (
		.clock_i(clock), .rst_n_i(rst_n), .req_valid_i(req_valid),
		.req_selector_i(sel), .req_windex_i(widx), .req_wlength_i(wlen),
		.link_state_i(link_state), .port_state_i(port_state), .suspended_i(susp),
		.connect_evt_i(ev[0]), .disconnect_evt_i(ev[1]), .overcurrent_evt_i(ev[2]),
		.resume_evt_i(ev[3]), .warm_done_i(warm_done), .warm_change_clr_i(conn_clr),
		.conn_change_clr_i(conn_clr), .oc_change_clr_i(conn_clr), .req_ready_o(req_ready),
		.resp_valid_o(resp_valid), .resp_error_o(resp_error), .cmd_port_o(cmd_port),
		.link_go_o(link_go), .link_go_state_o(go_state), .port_reset_o(pulse[5]),
		.port_warm_reset_o(pulse[4]), .port_power_on_o(pulse[3]),
		.port_disable_o(pulse[2]), .port_rx_detect_o(pulse[1]), .force_accept_o(pulse[0]),
		.fwd_allow_o(fwd_allow), .warm_change_o(warm_change), .wake_mask_o(wake_mask),
		.conn_change_o(conn_change), .oc_change_o(oc_change), .wake_o(wake)
	);
	port_model port_model_inst (
		.clock_i(clock), .rst_n_i(rst_n), .delay_i(delay), .set_i(set), .set_idx_i(sidx),
		.set_link_i(slink), .set_port_i(sport), .cmd_port_i(cmd_port), .link_go_i(link_go),
		.link_go_state_i(go_state), .port_disable_i(pulse[2]), .port_rx_detect_i(pulse[1]),
		.port_warm_reset_i(pulse[4]), .link_state_o(link_state), .port_state_o(port_state),
		.warm_done_o(warm_done)
	);

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Packs error, command count, pulses and last link target into one word
	task automatic chk_req(input string nm, input logic e_err, input logic [2:0] e_go,
		input logic [5:0] e_seen, input logic [2:0] e_st);
		chk(nm, {3'h0, e_err, e_go, e_seen, e_st}, {3'h0, err, go_n[2:0], seen, go_st});
	endtask

	// Idle handler takes on the first edge; a U3 wait is bounded by the loop
	task automatic req(input logic [7:0] s, input logic [15:0] x, input logic [15:0] l);
		go_n = 0;
		go_st = 3'h0;
		seen = 6'h00;
		rdy_lo = 1'b0;
		@(negedge clock);
		req_valid = 1'b1;
		sel = s;
		widx = x;
		wlen = l;
		@(posedge clock);
		for (int n = 0; n < 300; n++)
		begin
			// Registered pulses stand through the following low phase
			@(negedge clock);
			req_valid = 1'b0;
			seen = seen | pulse;
			rdy_lo = rdy_lo | !req_ready;
			if (link_go === 1'b1)
			begin
				if (go_n == 0)
					go_first = go_state;
				go_st = go_state;
				go_n++;
			end
			if (resp_valid === 1'b1)
				break;
		end
		err = resp_valid ? resp_error : 1'bx;
		repeat (4) @(negedge clock);
	endtask

	task automatic setp(input logic i, input logic [2:0] lk, input logic [2:0] pt);
		@(negedge clock);
		set = 1'b1;
		sidx = i;
		slink = lk;
		sport = pt;
		@(negedge clock);
		set = 1'b0;
	endtask

	task automatic evt(input int k, input int i);
		@(negedge clock);
		ev[k][i] = 1'b1;
		w = 1'b0;
		repeat (3)
		begin
			@(negedge clock);
			ev = '0;
			w = w | wake;
		end
	endtask

	task automatic t_link();
		setp(1'b0, 3'h0, 3'h3);
		req(LS, 16'h0101, 16'h0);
		chk_req("u1", 1'b0, 3'h1, 6'h00, 3'h1);
		req(LS, 16'h0001, 16'h0);
		chk_req("u0", 1'b0, 3'h1, 6'h00, 3'h0);
		req(LS, 16'h0201, 16'h0);
		chk_req("u2", 1'b0, 3'h1, 6'h00, 3'h2);
		req(LS, 16'h0101, 16'h0);
		chk_req("u1_from_u2", 1'b0, 3'h0, 6'h00, 3'h0);
	endtask

	task automatic t_u3();
		delay = 8'h14;
		setp(1'b0, 3'h1, 3'h3);
		req(LS, 16'h0301, 16'h0);
		chk_req("u3", 1'b0, 3'h2, 6'h00, 3'h3);
		chk("u3_first", 16'h0, {13'h0, go_first});
		chk("u3_wait", 16'h1, {15'h0, rdy_lo});
		repeat (25) @(negedge clock);
		chk("fwd", 16'h2, {14'h0, fwd_allow});
		delay = 8'h01;
	endtask

	task automatic t_noop();
		setp(1'b1, 3'h5, 3'h2);
		req(LS, 16'h0302, 16'h0);
		chk_req("u3_dis", 1'b0, 3'h0, 6'h00, 3'h0);
		req(FRC, 16'h0002, 16'h0);
		chk_req("frc_dis", 1'b0, 3'h0, 6'h00, 3'h0);
		req(LS, 16'h0502, 16'h0);
		chk_req("rxdet", 1'b0, 3'h1, 6'h02, 3'h5);
		req(LS, 16'h0402, 16'h0);
		chk_req("ssdis", 1'b0, 3'h1, 6'h04, 3'h4);
		chk("cmd_port", 16'h2, {8'h0, cmd_port});
		req(FRC, 16'h0001, 16'h0);
		chk_req("frc_en", 1'b0, 3'h0, 6'h01, 3'h0);
		req(PWR, 16'h0001, 16'h0);
		chk_req("pwr_on", 1'b0, 3'h0, 6'h00, 3'h0);
		setp(1'b1, 3'h0, 3'h0);
		req(RST, 16'h0002, 16'h0);
		chk_req("rst_off", 1'b0, 3'h0, 6'h00, 3'h0);
		req(PWR, 16'h0002, 16'h0);
		chk_req("pwr_off", 1'b0, 3'h0, 6'h08, 3'h0);
	endtask

	// Last entry is a valid timeout setting, accepted with no action
	task automatic t_err();
		logic [7:0]	es [6] = '{LS, 8'h01, RST, RST, RST, U1T};
		logic [15:0]	ex [6] = '{16'h0601, 16'h0001, 16'h0, 16'h0003, 16'h0001, 16'h7f01};
		logic [15:0]	el [6] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0001, 16'h0};
		for (int i = 0; i < 6; i++)
		begin
			req(es[i], ex[i], el[i]);
			chk_req("err", i < 5, 3'h0, 6'h00, 3'h0);
		end
	endtask

	task automatic t_warm();
		req(BH, 16'h0001, 16'h0);
		chk_req("warm", 1'b0, 3'h0, 6'h10, 3'h0);
		chk("warm_chg", 16'h1, {14'h0, warm_change});
		req(RST, 16'h0001, 16'h0);
		chk_req("prst", 1'b0, 3'h0, 6'h20, 3'h0);
	endtask

	task automatic t_wake();
		susp = 1'b1;
		req(MSK, 16'h0502, 16'h0);
		chk("mask", 16'h28, {10'h0, wake_mask});
		evt(0, 1);
		chk("wk_conn", 16'h1, {15'h0, w});
		evt(1, 1);
		chk("wk_disc", 16'h0, {15'h0, w});
		evt(2, 1);
		chk("wk_oc", 16'h1, {15'h0, w});
		chk("oc_chg", 16'h2, {14'h0, oc_change});
		evt(3, 0);
		chk("wk_resume", 16'h1, {15'h0, w});
		req(MSK, 16'h0201, 16'h0);
		evt(1, 0);
		chk("wk_disc0", 16'h1, {15'h0, w});
		evt(0, 0);
		chk("wk_conn0", 16'h0, {15'h0, w});
		chk("conn_chg", 16'h3, {14'h0, conn_change});
		@(negedge clock);
		conn_clr = 2'h3;
		@(negedge clock);
		conn_clr = 2'h0;
		@(negedge clock);
		chk("clr", 16'h0, {10'h0, warm_change, oc_change, conn_change});
		susp = 1'b0;
	endtask

	task automatic t_rst();
		@(negedge clock);
		rst_n = 1'b0;
		repeat (2) @(negedge clock);
		rst_n = 1'b1;
		chk("rst_mask", 16'h0, {10'h0, wake_mask});
		chk("rst_state", 16'h09,
			{10'h0, warm_change, req_ready, oc_change, fwd_allow[0]});
	endtask

	task automatic conclude();
		if (fail_count == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	// Span covers the slow U3 wait many times over
	initial
	begin
		#200000;
		fail_count++;
		conclude();
	end

	initial
	begin
		rst_n = 1'b0;
		req_valid = 1'b0;
		sel = 8'h00;
		widx = 16'h0;
		wlen = 16'h0;
		susp = 1'b0;
		set = 1'b0;
		sidx = 1'b0;
		slink = 3'h0;
		sport = 3'h0;
		delay = 8'h01;
		ev = '0;
		conn_clr = 2'h0;
		repeat (8) @(negedge clock);
		rst_n = 1'b1;
		chk("init_mask", 16'h0, {10'h0, wake_mask});
		t_link();
		t_u3();
		t_noop();
		t_err();
		t_warm();
		t_wake();
		t_rst();
		conclude();
	end
endmodule // hub_port_feature_handler_tb
